// ==== core/exec_pkg.sv ====
package exec_pkg;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned INSTR_W = 16;
    localparam int unsigned SEL_W = 4;
    localparam int unsigned VEC_W = 12;

    // Opcode matching: an instruction matches when (instr & mask) == value
    localparam logic [15:0] MASK_RR = 16'hff00;
    localparam logic [15:0] MASK_RI = 16'hfe00;
    localparam logic [15:0] MASK_R = 16'hfff0;
    localparam logic [15:0] MASK_ALL = 16'hffff;
    localparam logic [15:0] OP_CMPLT = 16'h0d00;
    localparam logic [15:0] OP_CMPNE = 16'h0f00;
    localparam logic [15:0] OP_CMPLTI = 16'h2200;
    localparam logic [15:0] OP_CMPNEI = 16'h2a00;
    localparam logic [15:0] OP_DECF = 16'h0090;
    localparam logic [15:0] OP_DECT = 16'h0080;
    localparam logic [15:0] OP_DECREMENT_TEST_POSITIVE = 16'h01a0;
    localparam logic [15:0] OP_DECLT = 16'h0180;
    localparam logic [15:0] OP_DECNE = 16'h01b0;
    localparam logic [15:0] OP_INCF = 16'h00b0;
    localparam logic [15:0] OP_INCT = 16'h00a0;
    localparam logic [15:0] OP_DIVS = 16'h3210;
    localparam logic [15:0] OP_DIVU = 16'h2c10;
    localparam logic [15:0] OP_FF1 = 16'h00e0;
    localparam logic [15:0] OP_DOZE = 16'h0006;

    // Field positions
    localparam int unsigned SEL_LSB = 0;
    localparam int unsigned SEC_LSB = 4;
    localparam int unsigned IMM_LSB = 4;
    localparam int unsigned IMM_W = 5;
    localparam logic [31:0] OIMM_OFFSET = 32'h0000_0001;

    localparam logic [VEC_W-1:0] DIVZ_VECTOR = 12'h00c;
    localparam logic [5:0] DIV_STEPS = 6'h20;
    localparam logic [5:0] NO_ONE_COUNT = 6'h20;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DIV = 2'b01,
        ST_DOZE = 2'b11
    } exec_mode_t;

    typedef struct packed {
        logic [INSTR_W-1:0] instr;
        logic [DATA_W-1:0] x_val;
        logic [DATA_W-1:0] y_val;
        logic [DATA_W-1:0] divisor_val;
    } issue_t;

    typedef struct packed {
        logic wr_en;
        logic [SEL_W-1:0] wr_index;
        logic [DATA_W-1:0] wr_data;
    } result_t;
endpackage : exec_pkg

// ==== core/seq_divider.sv ====
`timescale 1ns/100ps
module seq_divider #(
    parameter int unsigned W = 32
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic start,
    input wire logic signed_mode,
    input wire logic [W-1:0] dividend,
    input wire logic [W-1:0] divisor,
    output logic done,
    output logic [W-1:0] quotient
);
    import exec_pkg::*;

    typedef struct packed {
        logic busy;
        logic done;
        logic neg;
        logic [5:0] count;
        logic [W-1:0] rem;
        logic [W-1:0] quo;
        logic [W-1:0] dvs;
    } div_state_t;

    div_state_t s_q, s_d;
    logic [W-1:0] rem_sh;
    logic [W:0] diff;

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        rem_sh = {s_q.rem[W-2:0], s_q.quo[W-1]};
        diff = {1'b0, rem_sh} - {1'b0, s_q.dvs};
        if (start) begin
            // Signed operands are reduced to magnitudes; sign fixed at end
            s_d.busy = 1'b1;
            s_d.count = 6'h00;
            s_d.rem = '0;
            s_d.neg = signed_mode & (dividend[W-1] ^ divisor[W-1]);
            s_d.quo = (signed_mode && dividend[W-1]) ? -dividend : dividend;
            s_d.dvs = (signed_mode && divisor[W-1]) ? -divisor : divisor;
        end else if (s_q.busy) begin
            s_d.rem = diff[W] ? rem_sh : diff[W-1:0];
            s_d.quo = {s_q.quo[W-2:0], ~diff[W]};
            s_d.count = s_q.count + 6'h01;
            if (s_d.count == DIV_STEPS) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
                if (s_q.neg) begin
                    s_d.quo = -s_d.quo;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign done = s_q.done;
    assign quotient = s_q.quo;
endmodule : seq_divider

// ==== core/cmp_dec_div_exec.sv ====
// Notes on behaviour
// RL1: Signed less-than immediate, immediate is field plus one
// RL2: Register not-equal compare sets or clears flag
// RL3: Not-equal immediate uses field as 0..31
// RL4: Decrement only when flag clear; flag kept
// RL5: Decrement only when flag set; flag kept
// RL6: Decrement, flag set when result above zero
// RL7: Decrement, flag set when result below zero
// RL8: Decrement, flag set when result nonzero
// RL9: Increment only when flag clear; flag kept
// RL10: Signed divide by divisor register, quotient written
// RL11: Unsigned divide by divisor register, quotient written
// RL12: Zero divisor: no write, raise exception request
// RL13: Most negative by all-ones: quotient unchecked
// RL14: Privileged doze stops clock until interrupt
// RL15: Leading one finder returns distance from bit 31
// RL16: Four-bit field directly selects R0 to R15
// RL17: Not-equal immediate recognised by seven-bit opcode
// RL18: Flag visible to next instruction, no stall
`timescale 1ns/100ps
module cmp_dec_div_exec (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic issue_valid,
    input wire exec_pkg::issue_t issue,
    input wire logic supervisor,
    input wire logic irq_pending,
    input wire logic flag_load,
    input wire logic flag_value,
    output logic ready_q,
    output logic done_q,
    output exec_pkg::result_t result_q,
    output logic cond_q,
    output logic divz_req_q,
    output logic [exec_pkg::VEC_W-1:0] exc_vector_q,
    output logic doze_q
);
    import exec_pkg::*;

    typedef struct packed {
        exec_mode_t mode;
        logic ready;
        logic done;
        result_t res;
        logic cond;
        logic divz;
        logic [VEC_W-1:0] vec;
        logic doze;
    } exec_state_t;

    exec_state_t s_q, s_d;
    logic accept;
    logic [DATA_W-1:0] x;
    logic [DATA_W-1:0] x_dec;
    logic [DATA_W-1:0] x_inc;
    logic [DATA_W-1:0] oimm;
    logic [DATA_W-1:0] imm;
    logic [SEL_W-1:0] sel;
    logic is_lti, is_lt, is_ne, is_nei, is_decf, is_dect, is_decrement_test_positive;
    logic is_declt, is_decne, is_incf, is_inct, is_divs, is_divu;
    logic is_ff1, is_doze, is_div, div_start, div_done;
    logic [DATA_W-1:0] div_quo;

    function automatic logic op_is(input logic [15:0] ins,
                                   input logic [15:0] val,
                                   input logic [15:0] mask);
        op_is = (ins & mask) == val;
    endfunction : op_is

    function automatic logic [5:0] lead_count(input logic [31:0] v);
        lead_count = NO_ONE_COUNT;
        for (int i = 0; i < 32; i++) begin
            if (v[i]) begin
                lead_count = 6'(31 - i);
            end
        end
    endfunction : lead_count

    assign x = issue.x_val;
    assign x_dec = x - 32'h0000_0001;
    assign x_inc = x + 32'h0000_0001;
    assign sel = issue.instr[SEL_LSB +: SEL_W]; // see RL16
    assign imm = 32'(issue.instr[IMM_LSB +: IMM_W]); // see RL3
    assign oimm = imm + OIMM_OFFSET; // see RL1
    assign is_lt = op_is(issue.instr, OP_CMPLT, MASK_RR);
    assign is_ne = op_is(issue.instr, OP_CMPNE, MASK_RR);
    assign is_lti = op_is(issue.instr, OP_CMPLTI, MASK_RI);
    assign is_nei = op_is(issue.instr, OP_CMPNEI, MASK_RI); // see RL17
    assign is_decf = op_is(issue.instr, OP_DECF, MASK_R);
    assign is_dect = op_is(issue.instr, OP_DECT, MASK_R);
    assign is_decrement_test_positive = op_is(issue.instr, OP_DECREMENT_TEST_POSITIVE, MASK_R);
    assign is_declt = op_is(issue.instr, OP_DECLT, MASK_R);
    assign is_decne = op_is(issue.instr, OP_DECNE, MASK_R);
    assign is_incf = op_is(issue.instr, OP_INCF, MASK_R);
    assign is_inct = op_is(issue.instr, OP_INCT, MASK_R);
    assign is_divs = op_is(issue.instr, OP_DIVS, MASK_R);
    assign is_divu = op_is(issue.instr, OP_DIVU, MASK_R);
    assign is_ff1 = op_is(issue.instr, OP_FF1, MASK_R);
    assign is_doze = op_is(issue.instr, OP_DOZE, MASK_ALL);
    assign is_div = is_divs | is_divu;
    assign accept = ce & issue_valid & s_q.ready;
    assign div_start = accept & is_div & (issue.divisor_val != '0);

    seq_divider #(
        .W(DATA_W)
    ) u_div (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .start(div_start),
        .signed_mode(is_divs),
        .dividend(x),
        .divisor(issue.divisor_val),
        .done(div_done),
        .quotient(div_quo)
    );

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        s_d.divz = 1'b0;
        s_d.res.wr_en = 1'b0;
        if (flag_load) begin
            s_d.cond = flag_value;
        end
        unique case (s_q.mode)
            ST_IDLE: begin
                if (issue_valid && s_q.ready) begin
                    s_d.done = 1'b1;
                    s_d.res.wr_index = sel; // see RL16
                    s_d.res.wr_data = x;
                    // Flag held here so the next instruction sees it
                    if (is_lti) begin
                        s_d.cond = $signed(x) < $signed(oimm); // see RL1
                    end else if (is_lt) begin
                        s_d.cond = $signed(x) < $signed(issue.y_val);
                    end else if (is_ne) begin
                        s_d.cond = x != issue.y_val; // see RL2
                    end else if (is_nei) begin
                        s_d.cond = x != imm; // see RL3
                    end else if (is_decf) begin
                        s_d.res.wr_en = ~s_q.cond; // see RL4 RL18
                        s_d.res.wr_data = x_dec;
                    end else if (is_dect) begin
                        s_d.res.wr_en = s_q.cond; // see RL5 RL18
                        s_d.res.wr_data = x_dec;
                    end else if (is_incf) begin
                        s_d.res.wr_en = ~s_q.cond; // see RL9 RL18
                        s_d.res.wr_data = x_inc;
                    end else if (is_inct) begin
                        s_d.res.wr_en = s_q.cond;
                        s_d.res.wr_data = x_inc;
                    end else if (is_decrement_test_positive) begin
                        s_d.res.wr_en = 1'b1;
                        s_d.res.wr_data = x_dec;
                        s_d.cond = $signed(x_dec) > 0; // see RL6
                    end else if (is_declt) begin
                        s_d.res.wr_en = 1'b1;
                        s_d.res.wr_data = x_dec;
                        s_d.cond = x_dec[DATA_W-1]; // see RL7
                    end else if (is_decne) begin
                        s_d.res.wr_en = 1'b1;
                        s_d.res.wr_data = x_dec;
                        s_d.cond = x_dec != '0; // see RL8
                    end else if (is_ff1) begin
                        s_d.res.wr_en = 1'b1;
                        s_d.res.wr_data = 32'(lead_count(x)); // see RL15
                    end else if (is_div) begin
                        if (issue.divisor_val == '0) begin
                            s_d.divz = 1'b1; // see RL12
                            s_d.vec = DIVZ_VECTOR;
                        end else begin
                            s_d.done = 1'b0;
                            s_d.ready = 1'b0;
                            s_d.mode = ST_DIV; // see RL10 RL11
                        end
                    end else if (is_doze && supervisor) begin
                        s_d.done = 1'b0;
                        s_d.ready = 1'b0;
                        s_d.doze = 1'b1; // see RL14
                        s_d.mode = ST_DOZE;
                    end
                end
            end
            ST_DIV: begin
                if (div_done) begin
                    // Quotient of most negative by all-ones is left as is
                    s_d.res.wr_en = 1'b1; // see RL10 RL11 RL13
                    s_d.res.wr_data = div_quo;
                    s_d.done = 1'b1;
                    s_d.ready = 1'b1;
                    s_d.mode = ST_IDLE;
                end
            end
            ST_DOZE: begin
                if (irq_pending) begin
                    s_d.doze = 1'b0; // see RL14
                    s_d.done = 1'b1;
                    s_d.ready = 1'b1;
                    s_d.mode = ST_IDLE;
                end
            end
            default: begin
                s_d.mode = ST_IDLE;
                s_d.ready = 1'b1;
                s_d.doze = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '{mode: ST_IDLE, ready: 1'b1, default: '0};
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign ready_q = s_q.ready;
    assign done_q = s_q.done;
    assign result_q = s_q.res;
    assign cond_q = s_q.cond;
    assign divz_req_q = s_q.divz;
    assign exc_vector_q = s_q.vec;
    assign doze_q = s_q.doze;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    property p_lti;
        accept && is_lti && !flag_load |=>
            cond_q == ($signed($past(x)) < $signed($past(oimm)));
    endproperty
    a_lti: assert property (p_lti) // see RL1
        else $error("lti flag wrong");

    property p_ne;
        accept && is_ne && !flag_load |=>
            cond_q == ($past(x) != $past(issue.y_val)) && !result_q.wr_en;
    endproperty
    a_ne: assert property (p_ne) // see RL2
        else $error("ne flag wrong");

    property p_nei;
        accept && is_nei && !flag_load |=>
            cond_q == ($past(x) != $past(imm));
    endproperty
    a_nei: assert property (p_nei) // see RL3 RL17
        else $error("nei flag wrong");

    property p_decf;
        accept && is_decf && !flag_load |=>
            result_q.wr_en == !$past(cond_q) && $stable(cond_q)
            && result_q.wr_data == $past(x) - 32'h0000_0001;
    endproperty
    a_decf: assert property (p_decf) // see RL4 RL18
        else $error("decf wrong");

    property p_dect;
        accept && is_dect && !flag_load |=>
            result_q.wr_en == $past(cond_q) && $stable(cond_q);
    endproperty
    a_dect: assert property (p_dect) // see RL5 RL18
        else $error("dect wrong");

    property p_decrement_test_positive;
        accept && is_decrement_test_positive && !flag_load |=> result_q.wr_en
            && cond_q == ($signed($past(x) - 32'h0000_0001) > 0);
    endproperty
    a_decrement_test_positive: assert property (p_decrement_test_positive) // see RL6
        else $error("decrement_test_positive flag wrong");

    property p_declt;
        accept && is_declt && !flag_load |=> result_q.wr_en
            && cond_q == ($signed($past(x) - 32'h0000_0001) < 0);
    endproperty
    a_declt: assert property (p_declt) // see RL7
        else $error("declt flag wrong");

    property p_decne;
        accept && is_decne && !flag_load |=> result_q.wr_en
            && cond_q == ($past(x) != 32'h0000_0001);
    endproperty
    a_decne: assert property (p_decne) // see RL8
        else $error("decne flag wrong");

    property p_incf;
        accept && is_incf && !flag_load |=>
            result_q.wr_en == !$past(cond_q)
            && result_q.wr_data == $past(x) + 32'h0000_0001;
    endproperty
    a_incf: assert property (p_incf) // see RL9 RL18
        else $error("incf wrong");

    property p_dec_data;
        accept && (is_decrement_test_positive || is_declt || is_decne) |=>
            result_q.wr_data == $past(x) - 32'h0000_0001;
    endproperty
    a_dec_data: assert property (p_dec_data) // see RL6 RL7 RL8
        else $error("decrement result wrong");

    sequence s_div_go;
        accept && is_div && issue.divisor_val != '0;
    endsequence
    // Upper bound leaves room for six frozen cycles
    sequence s_div_end;
        ##[34:40] (done_q && result_q.wr_en && ready_q);
    endsequence
    property p_divres;
        s_div_go |-> s_div_end;
    endproperty
    a_divres: assert property (p_divres) // see RL10 RL11
        else $error("divide result missing");

    property p_divwait;
        s_div_go |=> !ready_q && !done_q && !divz_req_q;
    endproperty
    a_divwait: assert property (p_divwait) // see RL10 RL11
        else $error("div not busy");

    property p_divz;
        accept && is_div && issue.divisor_val == '0 |=>
            divz_req_q && !result_q.wr_en && exc_vector_q == DIVZ_VECTOR;
    endproperty
    a_divz: assert property (p_divz) // see RL12
        else $error("divide by zero missed");

    property p_ff1;
        accept && is_ff1 |=> result_q.wr_en && ($past(x) == '0
            ? result_q.wr_data == 32'h0000_0020
            : result_q.wr_data < 32'h0000_0020
            && ($past(x) << result_q.wr_data) >= 32'h8000_0000
            && ($past(x) >> (32'h0000_0020 - result_q.wr_data)) == '0);
    endproperty
    a_ff1: assert property (p_ff1) // see RL15
        else $error("finder wrong");

    property p_doze;
        accept && is_doze && supervisor |=> doze_q && !ready_q;
    endproperty
    a_doze: assert property (p_doze) // see RL14
        else $error("doze not entered");

    property p_doze_wake;
        ce && doze_q && irq_pending |=>
            !doze_q && done_q && ready_q && !result_q.wr_en;
    endproperty
    a_doze_wake: assert property (p_doze_wake) // see RL14
        else $error("doze not left");

    property p_sel;
        accept && !is_div && !is_doze |=>
            result_q.wr_index == $past(sel) && done_q;
    endproperty
    a_sel: assert property (p_sel) // see RL16
        else $error("wrong register index");
endmodule : cmp_dec_div_exec

// ==== verif/reg_file_model.sv ====
`timescale 1ns/100ps
module reg_file_model (
    input wire logic clk,
    input wire logic [15:0] instr,
    input wire exec_pkg::result_t result,
    input wire logic ld_en,
    input wire logic [3:0] ld_idx,
    input wire logic [31:0] ld_val,
    output exec_pkg::issue_t issue
);
    import exec_pkg::*;
    logic [DATA_W-1:0] regs [16];

    // Preload from the bench wins over a write-back in the same cycle
    always_ff @(posedge clk) begin
        if (ld_en) begin
            regs[ld_idx] <= ld_val;
        end else if (result.wr_en === 1'b1) begin
            regs[result.wr_index] <= result.wr_data;
        end
    end

    always_comb begin
        issue.instr = instr;
        issue.x_val = regs[instr[SEL_LSB +: SEL_W]];
        issue.y_val = regs[instr[SEC_LSB +: SEL_W]];
        issue.divisor_val = regs[1];
    end
endmodule : reg_file_model

// ==== verif/test_cmp_dec_div_exec.sv ====
`timescale 1ns/100ps
`define CK(what, exp, got) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) begin \
            failures++; \
            $display("[FAIL] %s exp %h got %h", what, exp, got); \
        end \
    end
module test_cmp_dec_div_exec;
    import exec_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic ce = 1'b1;
    logic issue_valid = 1'b0;
    logic supervisor = 1'b0;
    logic irq_pending = 1'b0;
    logic flag_load = 1'b0;
    logic flag_value = 1'b0;
    logic [15:0] instr = 16'h0000;
    logic ld_en = 1'b0;
    logic [3:0] ld_idx = 4'h0;
    logic [31:0] ld_val = 32'h0;
    issue_t issue;
    result_t result_q;
    logic ready_q;
    logic done_q;
    logic cond_q;
    logic divz_req_q;
    logic doze_q;
    logic [VEC_W-1:0] exc_vector_q;
    logic last_wr;
    logic last_divz;
    int failures = 0;
    int samples_checked = 0;
    int cyc;

    always #50 clk = ~clk;

    cmp_dec_div_exec i_cmp_dec_div_exec (
        .clk(clk), .reset(reset), .ce(ce), .issue_valid(issue_valid),
        .issue(issue), .supervisor(supervisor), .irq_pending(irq_pending),
        .flag_load(flag_load), .flag_value(flag_value), .ready_q(ready_q),
        .done_q(done_q), .result_q(result_q), .cond_q(cond_q),
        .divz_req_q(divz_req_q), .exc_vector_q(exc_vector_q),
        .doze_q(doze_q)
    );

    reg_file_model i_reg_file_model (
        .clk(clk), .instr(instr), .result(result_q), .ld_en(ld_en),
        .ld_idx(ld_idx), .ld_val(ld_val), .issue(issue)
    );

    function automatic logic [31:0] rg(input int i);
        return i_reg_file_model.regs[i];
    endfunction : rg

    task automatic end_of_test();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick

    task automatic load(input logic [3:0] i, input logic [31:0] v);
        ld_en = 1'b1;
        ld_idx = i;
        ld_val = v;
        tick();
        ld_en = 1'b0;
        tick();
    endtask : load

    task automatic set_flag(input logic v);
        flag_load = 1'b1;
        flag_value = v;
        tick();
        flag_load = 1'b0;
        tick();
    endtask : set_flag

    task automatic go(input logic [15:0] op);
        int n;
        n = 0;
        while (ready_q !== 1'b1 && n < 100) begin
            tick();
            n++;
        end
        if (ready_q !== 1'b1) begin
            $display("[FAIL] ready wait exp 1 got %b", ready_q);
            failures++;
            end_of_test();
        end
        instr = op;
        issue_valid = 1'b1;
        tick();
        issue_valid = 1'b0;
    endtask : go

    task automatic wdone();
        cyc = 0;
        while (done_q !== 1'b1 && cyc < 300) begin
            tick();
            cyc++;
        end
        last_wr = result_q.wr_en;
        last_divz = divz_req_q;
        if (done_q !== 1'b1) begin
            $display("[FAIL] done wait exp 1 got %b", done_q);
            failures++;
            end_of_test();
        end
    endtask : wdone

    task automatic ex(input logic [15:0] op);
        go(op);
        wdone();
        tick();
    endtask : ex

    task automatic t_cmp();
        logic [31:0] xv [4] = '{32'hffff_ffff, 32'h1, 32'h1f, 32'h20};
        logic [4:0] fv [4] = '{5'h00, 5'h00, 5'h1f, 5'h1f};
        logic el [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        logic en [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
        for (int i = 0; i < 4; i++) begin
            load(4'h7, xv[i]);
            set_flag(!el[i]);
            ex(OP_CMPLTI | {7'h00, fv[i], 4'h7});
            `CK("lti", el[i], cond_q);
            set_flag(!en[i]);
            ex(OP_CMPNEI | {7'h00, fv[i], 4'h7});
            `CK("nei", en[i], cond_q);
            load(4'ha, 32'h1f);
            set_flag(xv[i] == 32'h1f);
            ex(OP_CMPNE | 16'h00a7);
            `CK("ne", (xv[i] != 32'h1f), cond_q);
            set_flag($signed(xv[i]) >= $signed(32'h1f));
            ex(OP_CMPLT | 16'h00a7);
            `CK("lt", ($signed(xv[i]) < $signed(32'h1f)), cond_q);
        end
        // R7 holds 0x20, so a false match as imm 1 would set the flag
        set_flag(1'b0);
        ex(16'h2817);
        `CK("near miss wr", 1'b0, last_wr);
        `CK("near miss flag", 1'b0, cond_q);
    endtask : t_cmp

    task automatic t_cond();
        logic [15:0] ops [4] = '{OP_DECF, OP_DECT, OP_INCF, OP_INCT};
        logic f;
        logic fire;
        for (int k = 0; k < 8; k++) begin
            f = k[0];
            fire = (k[1] == 1'b0) ? !f : f;
            load(4'hc, 32'h10);
            set_flag(f);
            ex(ops[k >> 1] | 16'h000c);
            `CK("cond reg", fire ? (k < 4 ? 32'hf : 32'h11) : 32'h10,
                rg(12));
            `CK("cond flag", f, cond_q);
        end
    endtask : t_cond

    task automatic t_dec();
        logic [15:0] ops [3] = '{OP_DECREMENT_TEST_POSITIVE, OP_DECLT, OP_DECNE};
        logic [31:0] xv [4] = '{32'h1, 32'h2, 32'h0, 32'h8000_0000};
        logic [31:0] n;
        logic e;
        for (int i = 0; i < 4; i++) begin
            for (int k = 0; k < 3; k++) begin
                n = xv[i] - 32'h1;
                e = (k == 0) ? ($signed(n) > 0) :
                    (k == 1) ? ($signed(n) < 0) : (n != 32'h0);
                load(4'hf, xv[i]);
                set_flag(!e);
                ex(ops[k] | 16'h000f);
                `CK("dec reg", n, rg(15));
                `CK("dec flag", e, cond_q);
            end
        end
    endtask : t_dec

    task automatic t_div();
        logic [15:0] ops [2] = '{OP_DIVS, OP_DIVU};
        load(4'h1, 32'h2);
        load(4'h6, 32'hffff_fff9);
        go(OP_DIVS | 16'h0006);
        tick();
        `CK("div busy", 1'b0, ready_q);
        ce = 1'b0;
        repeat (5) tick();
        ce = 1'b1;
        wdone();
        `CK("divs time", 32, cyc);
        tick();
        `CK("divs q", 32'hffff_fffd, rg(6));
        load(4'h6, 32'hffff_fff9);
        ex(OP_DIVU | 16'h0006);
        `CK("divu q", 32'h7fff_fffc, rg(6));
        load(4'h1, 32'h0);
        for (int k = 0; k < 2; k++) begin
            load(4'h6, 32'h5);
            ex(ops[k] | 16'h0006);
            `CK("divz req", 1'b1, last_divz);
            `CK("divz wr", 1'b0, last_wr);
            `CK("divz vec", 12'h00c, exc_vector_q);
            `CK("divz reg", 32'h5, rg(6));
        end
        load(4'h1, 32'hffff_ffff);
        load(4'h6, 32'h8000_0000);
        ex(OP_DIVS | 16'h0006);
        `CK("min div req", 1'b0, last_divz);
        `CK("min div wr", 1'b1, last_wr);
    endtask : t_div

    task automatic t_ff1();
        logic [31:0] xv [4] = '{32'h8000_0000, 32'h1, 32'h0, 32'h1_0000};
        logic [31:0] ev [4] = '{32'h0, 32'h1f, 32'h20, 32'hf};
        for (int i = 0; i < 4; i++) begin
            load(4'hd, xv[i]);
            ex(OP_FF1 | 16'h000d);
            `CK("ff1", ev[i], rg(13));
        end
    endtask : t_ff1

    task automatic t_doze();
        ex(OP_DOZE);
        `CK("user doze", 1'b0, doze_q);
        `CK("user doze ready", 1'b1, ready_q);
        supervisor = 1'b1;
        go(OP_DOZE);
        repeat (5) tick();
        `CK("dozing", 1'b1, doze_q);
        `CK("doze busy", 1'b0, ready_q);
        irq_pending = 1'b1;
        wdone();
        irq_pending = 1'b0;
        tick();
        `CK("woken", 1'b0, doze_q);
        `CK("woken ready", 1'b1, ready_q);
    endtask : t_doze

    task automatic t_b2b();
        load(4'h4, 32'h20);
        load(4'h3, 32'h5);
        set_flag(1'b1);
        instr = OP_CMPNEI | 16'h0053;
        issue_valid = 1'b1;
        tick();
        instr = OP_INCF | 16'h0004;
        tick();
        issue_valid = 1'b0;
        repeat (3) tick();
        `CK("b2b flag", 1'b0, cond_q);
        `CK("b2b reg", 32'h21, rg(4));
    endtask : t_b2b

    initial begin
        repeat (3) @(posedge clk);
        #1;
        reset = 1'b0;
        `CK("rst ready", 1'b1, ready_q);
        `CK("rst done", 1'b0, done_q);
        `CK("rst divz", 1'b0, divz_req_q);
        t_cmp();
        t_cond();
        t_dec();
        t_div();
        t_ff1();
        t_b2b();
        t_doze();
        end_of_test();
    end
endmodule : test_cmp_dec_div_exec
